// File: rtl/usr_core.sv
// Serial transceiver core: processor port, control-word sequencer, receiver and flags
`timescale 1ns/100ps
// ***********************************************************
// ***********************************************************
module usr_core #(
  parameter int DATA_W = 8,
  parameter int CNT_W  = 7
) (
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic              cs_n_i,
  input  wire logic              rd_n_i,
  input  wire logic              wr_n_i,
  input  wire logic              cd_i,
  input  wire logic [DATA_W-1:0] data_i,
  output logic      [DATA_W-1:0] data_o,
  output logic                   data_oe_o,
  input  wire logic              receive_bit_clock_i,
  input  wire logic              rxd_i,
  input  wire logic              transmit_bit_clock_i,
  input  wire logic              cts_n_i,
  output logic                   txd_o,
  output logic                   receive_char_available_o,
  output logic                   transmit_holding_free_o,
  output logic                   tx_empty_o,
  input  wire logic              sync_found_or_line_break_i,
  output logic                   sync_found_or_line_break_o,
  output logic                   sync_found_or_line_break_oe_o
);
  import usr_pkg::*;

  if (DATA_W != 8 || CNT_W < 7) begin : g_bad_param
    $error("usr_core serves an 8-bit port and at least 7-bit counters only");
  end

  // ***********************************************************
  // Processor strobes
  // ***********************************************************
  logic wr_act;
  logic rd_act;
  logic wr_q;
  logic rd_q;
  logic wr_ctl;
  logic wr_dat;
  logic rd_sts;
  logic rd_dat;

  assign wr_act = ~cs_n_i & ~wr_n_i;
  assign rd_act = ~cs_n_i & ~rd_n_i;
  assign wr_ctl = wr_act & ~wr_q & cd_i;
  assign wr_dat = wr_act & ~wr_q & ~cd_i;
  assign rd_sts = rd_act & ~rd_q & cd_i;
  assign rd_dat = rd_act & ~rd_q & ~cd_i;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      wr_q <= wr_act;
      rd_q <= rd_act;
    end
  end

  // ***********************************************************
  // Control-word sequencer
  // ***********************************************************
  usr_phase_t phase;
  logic [7:0] mode;
  logic [7:0] cmd;
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic       srst;
  logic       erst;
  logic       hunt_go;

  // A command with the restart bit wipes the run state, so the next control write is a mode word
  assign srst    = wr_ctl && phase == PH_CMD && data_i[CMD_IRST];
  assign erst    = wr_ctl && phase == PH_CMD && data_i[CMD_ERST] && !srst;
  assign hunt_go = wr_ctl && phase == PH_CMD && data_i[CMD_HUNT] && !srst;

  // Zero-filled mode writes land in sync mode, so the host init sequence drains into the command phase
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase <= PH_MODE;
      mode  <= MODE_RST;
      cmd   <= CMD_RST;
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
    end else if (wr_ctl) begin
      unique case (phase)
        PH_MODE: begin
          mode  <= data_i;
          phase <= (data_i[MD_BAUD_LSB +: 2] == BAUD_SYNC) ? PH_SYNC1 : PH_CMD;
        end
        PH_SYNC1: begin
          sync1 <= data_i;
          phase <= mode[MD_SINGLE] ? PH_CMD : PH_SYNC2;
        end
        PH_SYNC2: begin
          sync2 <= data_i;
          phase <= PH_CMD;
        end
        PH_CMD: begin
          if (data_i[CMD_IRST]) begin
            phase <= PH_MODE;
            cmd   <= CMD_RST;
          end else begin
            cmd <= data_i;
          end
        end
      endcase
    end
  end

  // ***********************************************************
  // Decoded mode fields
  // ***********************************************************
  logic       is_sync;
  logic       ext_sync;
  logic       pen;
  logic [3:0] nlen;
  logic [6:0] edges;
  logic [7:0] cmask;

  assign is_sync  = mode[MD_BAUD_LSB +: 2] == BAUD_SYNC;
  assign ext_sync = is_sync && mode[MD_EXT_SYNC];
  assign pen      = mode[MD_PEN];
  assign nlen     = CHAR_MIN + {2'h0, mode[MD_LEN_LSB +: 2]};
  assign edges    = usr_edges(mode[MD_BAUD_LSB +: 2]);
  assign cmask    = 8'hff >> (CHAR_MAX - nlen);

  // ***********************************************************
  // Bit clock edges
  // ***********************************************************
  usr_edge_if rx_ck ();
  usr_edge_if tx_ck ();

  usr_edge u_rx_edge (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .line_i (receive_bit_clock_i),
    .edge_o (rx_ck)
  );

  usr_edge u_tx_edge (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .line_i (transmit_bit_clock_i),
    .edge_o (tx_ck)
  );

  // ***********************************************************
  // Receiver sequencer
  // ***********************************************************
  usr_rx_t    rx_st;
  logic [6:0] rx_cnt;
  logic [2:0] bitn;
  logic [7:0] rx_sh;
  logic [7:0] next_sh;
  logic [7:0] aligned;
  logic       line_q;
  logic       syn_in_q;
  logic       ext_arm;
  logic       samp;
  logic       last_bit;
  logic       hunt_hit;

  assign next_sh  = {rxd_i, rx_sh[7:1]};
  assign aligned  = next_sh >> (CHAR_MAX - nlen);
  assign samp     = rx_ck.rise && rx_cnt == '0 && rx_st != RX_IDLE && !srst && !hunt_go;
  assign last_bit = {1'b0, bitn} == nlen - 4'h1;
  assign hunt_hit = samp && ((rx_st == RX_HUNT && mode[MD_SINGLE] && aligned == (sync1 & cmask)) ||
                             (rx_st == RX_SYN2 && last_bit && aligned == (sync2 & cmask)));

  // Line level at the previous rising edge for falling edge search; external sync input as of the previous system clock
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      line_q   <= 1'b1;
      syn_in_q <= 1'b0;
    end else begin
      syn_in_q <= sync_found_or_line_break_i;
      if (rx_ck.rise) begin
        line_q <= rxd_i;
      end
    end
  end

  // Parity after a hunted sync character is skipped, after the first or the second sync alike
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_st   <= RX_IDLE;
      rx_cnt  <= '0;
      bitn    <= '0;
      rx_sh   <= '0;
      ext_arm <= 1'b0;
    end else if (srst) begin
      rx_st   <= RX_IDLE;
      rx_cnt  <= '0;
      bitn    <= '0;
      rx_sh   <= '0;
      ext_arm <= 1'b0;
    end else if (hunt_go && is_sync && !ext_sync) begin
      rx_st  <= RX_HUNT;
      rx_cnt <= '0;
      rx_sh  <= '0;
    end else if (rx_st == RX_IDLE) begin
      if (ext_sync) begin
        if (ext_arm && rx_ck.fall) begin
          rx_st   <= RX_DATA;
          rx_cnt  <= '0;
          bitn    <= '0;
          ext_arm <= 1'b0;
        end else if (sync_found_or_line_break_i && !syn_in_q) begin
          ext_arm <= 1'b1;
        end
      end else if (!is_sync && rx_ck.rise && line_q && !rxd_i) begin
        bitn <= '0;
        if (edges == RATE_X1) begin
          rx_st  <= RX_DATA;
          rx_cnt <= '0;
        end else begin
          rx_st  <= RX_START;
          rx_cnt <= (edges >> 1) - 7'h1;
        end
      end
    end else if (rx_ck.rise) begin
      if (rx_cnt != '0) begin
        rx_cnt <= rx_cnt - 7'h1;
      end else begin
        rx_cnt <= edges - 7'h1;
        unique case (rx_st)
          RX_IDLE: begin
          end
          RX_START: begin
            rx_st <= rxd_i ? RX_IDLE : RX_DATA;
          end
          RX_DATA: begin
            rx_sh <= next_sh;
            bitn  <= last_bit ? 3'h0 : bitn + 3'h1;
            if (last_bit) begin
              rx_st <= pen ? RX_PAR : (is_sync ? RX_DATA : RX_STOP);
            end
          end
          RX_PAR: begin
            rx_st <= is_sync ? RX_DATA : RX_STOP;
          end
          RX_STOP: begin
            rx_st <= RX_IDLE;
          end
          RX_HUNT: begin
            rx_sh <= next_sh;
            if (aligned == (sync1 & cmask)) begin
              rx_st <= mode[MD_SINGLE] ? RX_DATA : RX_SYN2;
              bitn  <= '0;
            end
          end
          RX_SYN2: begin
            rx_sh <= next_sh;
            bitn  <= last_bit ? 3'h0 : bitn + 3'h1;
            if (last_bit) begin
              rx_st <= hunt_hit ? RX_DATA : RX_HUNT;
            end
          end
        endcase
      end
    end
  end

  // ***********************************************************
  // Character capture
  // ***********************************************************
  logic       rx_done;
  logic [7:0] done_dat;
  logic       done_par_ok;
  logic       done_stop;
  logic       done_pzero;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_done     <= 1'b0;
      done_dat    <= '0;
      done_par_ok <= 1'b1;
      done_stop   <= 1'b1;
      done_pzero  <= 1'b1;
    end else begin
      rx_done <= 1'b0;
      if (samp && rx_st == RX_DATA && last_bit) begin
        done_dat    <= aligned;
        done_par_ok <= 1'b1;
        done_stop   <= 1'b1;
        done_pzero  <= 1'b1;
        rx_done     <= is_sync && !pen;
      end else if (samp && rx_st == RX_PAR) begin
        done_par_ok <= rxd_i == (^done_dat ^ ~mode[MD_PEVEN]);
        done_pzero  <= ~rxd_i;
        rx_done     <= is_sync;
      end else if (samp && rx_st == RX_STOP) begin
        done_stop <= rxd_i;
        rx_done   <= 1'b1;
      end
    end
  end

  // ***********************************************************
  // Receive buffer and flags
  // ***********************************************************
  logic [7:0] rbuf;
  logic       receive_char_available;
  logic       ld;
  logic       pe;
  logic       oe;
  logic       fe;
  logic       brk;
  logic       sync_found_pin;

  assign ld = rx_done && cmd[CMD_RXE] && done_stop;

  // A new character wins over a same-cycle read, so ready is never lost
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rbuf  <= '0;
      receive_char_available <= 1'b0;
      oe    <= 1'b0;
    end else if (srst) begin
      receive_char_available <= 1'b0;
      oe    <= 1'b0;
    end else begin
      if (ld) begin
        rbuf  <= done_dat;
        receive_char_available <= 1'b1;
      end else if (rd_dat) begin
        receive_char_available <= 1'b0;
      end
      if (ld && receive_char_available && !rd_dat) begin
        oe <= 1'b1;
      end else if (erst) begin
        oe <= 1'b0;
      end
    end
  end

  // Parity errors only flag; a bad stop bit also drops the character; the receiver keeps running regardless
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pe <= 1'b0;
      fe <= 1'b0;
    end else if (srst) begin
      pe <= 1'b0;
      fe <= 1'b0;
    end else begin
      if (rx_done && !done_par_ok) begin
        pe <= 1'b1;
      end else if (erst) begin
        pe <= 1'b0;
      end
      if (rx_done && !is_sync && !done_stop) begin
        fe <= 1'b1;
      end else if (erst) begin
        fe <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      brk    <= 1'b0;
      sync_found_pin <= 1'b0;
    end else if (srst) begin
      brk    <= 1'b0;
      sync_found_pin <= 1'b0;
    end else begin
      if (rx_done && !is_sync && done_dat == '0 && done_pzero && !done_stop) begin
        brk <= 1'b1;
      end else if (rxd_i) begin
        brk <= 1'b0;
      end
      if (hunt_hit) begin
        sync_found_pin <= 1'b1;
      end else if (rd_sts) begin
        sync_found_pin <= 1'b0;
      end
    end
  end

  // ***********************************************************
  // Transmit holding register
  // ***********************************************************
  logic [7:0] thr;
  logic       thr_full;
  logic       tx_busy;
  logic       tx_go;
  logic       prog_done;

  assign prog_done = phase == PH_CMD;
  assign tx_go     = thr_full && !tx_busy && cmd[CMD_TRANSMIT_ENABLE_BIT] && !cts_n_i;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      thr      <= '0;
      thr_full <= 1'b0;
    end else if (srst) begin
      thr_full <= 1'b0;
    end else if (wr_dat) begin
      thr      <= data_i;
      thr_full <= 1'b1;
    end else if (tx_go) begin
      thr_full <= 1'b0;
    end
  end

  usr_tx u_tx (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .srst_i (srst),
    .tclk   (tx_ck),
    .mode_i (mode),
    .go_i   (tx_go),
    .data_i (thr),
    .brk_i  (cmd[CMD_BRK]),
    .txd_o  (txd_o),
    .busy_o (tx_busy)
  );

  // ***********************************************************
  // Read path and pins
  // ***********************************************************
  logic [7:0] status;
  logic       transmit_holding_free_st;

  assign transmit_holding_free_st = prog_done && !thr_full;

  always_comb begin
    status           = '0;
    status[ST_TRANSMIT_HOLDING_FREE] = transmit_holding_free_st;
    status[ST_RECEIVE_CHAR_AVAILABLE] = receive_char_available;
    status[ST_TXE]   = !thr_full && !tx_busy;
    status[ST_PE]    = pe;
    status[ST_OE]    = oe;
    status[ST_FE]    = fe;
    status[ST_SYN]   = is_sync ? sync_found_pin : brk;
  end

  // Read data is caught at the strobe's leading edge and held while it lasts
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_o    <= '0;
      data_oe_o <= 1'b0;
    end else begin
      data_oe_o <= rd_act;
      if (rd_sts) begin
        data_o <= status;
      end else if (rd_dat) begin
        data_o <= rbuf;
      end
    end
  end

  assign receive_char_available_o      = receive_char_available;
  assign transmit_holding_free_o       = transmit_holding_free_st && cmd[CMD_TRANSMIT_ENABLE_BIT] && !cts_n_i;
  assign tx_empty_o                    = !thr_full && !tx_busy;
  assign sync_found_or_line_break_oe_o = !ext_sync;
  assign sync_found_or_line_break_o    = is_sync ? sync_found_pin : brk;

endmodule : usr_core

// File: rtl/usr_edge.sv
// Rising and falling edge detector for a bit clock sampled by the system clock
`timescale 1ns/100ps
module usr_edge (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic line_i,
  usr_edge_if.src   edge_o
);
  logic line_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      line_q <= 1'b0;
    end else begin
      line_q <= line_i;
    end
  end

  assign edge_o.rise = line_i & ~line_q;
  assign edge_o.fall = ~line_i & line_q;
endmodule : usr_edge

// File: rtl/usr_edge_if.sv
// Edge pulses of one sampled bit clock, passed between core modules
`timescale 1ns/100ps
interface usr_edge_if;
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface : usr_edge_if

// File: rtl/usr_pkg.sv
// Shared constants, field positions and types of the serial receiver core
package usr_pkg;

  // ***********************************************************
  // Mode word fields
  // ***********************************************************
  localparam int MD_BAUD_LSB = 0;
  localparam int MD_LEN_LSB  = 2;
  localparam int MD_PEN      = 4;
  localparam int MD_PEVEN    = 5;
  localparam int MD_STOP_LSB = 6;
  localparam int MD_EXT_SYNC = 6;
  localparam int MD_SINGLE   = 7;

  localparam logic [1:0] BAUD_SYNC = 2'h0;
  localparam logic [1:0] BAUD_X16  = 2'h2;
  localparam logic [1:0] BAUD_X64  = 2'h3;
  localparam logic [1:0] STOP_15   = 2'h2;
  localparam logic [1:0] STOP_TWO  = 2'h3;

  localparam logic [6:0] RATE_X1   = 7'h01;
  localparam logic [6:0] RATE_X16  = 7'h10;
  localparam logic [6:0] RATE_X64  = 7'h40;
  localparam logic [3:0] CHAR_MIN  = 4'h5;
  localparam logic [3:0] CHAR_MAX  = 4'h8;

  // ***********************************************************
  // Command word bits and status read layout
  // ***********************************************************
  localparam int CMD_TRANSMIT_ENABLE_BIT = 0;
  localparam int CMD_RXE  = 2;
  localparam int CMD_BRK  = 3;
  localparam int CMD_ERST = 4;
  localparam int CMD_IRST = 6;
  localparam int CMD_HUNT = 7;

  localparam int ST_TRANSMIT_HOLDING_FREE = 0;
  localparam int ST_RECEIVE_CHAR_AVAILABLE = 1;
  localparam int ST_TXE   = 2;
  localparam int ST_PE    = 3;
  localparam int ST_OE    = 4;
  localparam int ST_FE    = 5;
  localparam int ST_SYN   = 6;

  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CMD_RST  = 8'h00;
  localparam logic [7:0] SYNC_RST = 8'h00;

  typedef enum logic [1:0] {PH_MODE, PH_SYNC1, PH_SYNC2, PH_CMD} usr_phase_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_HUNT, RX_SYN2} usr_rx_t;

  function automatic logic [6:0] usr_edges(input logic [1:0] baud);
    return (baud == BAUD_X16) ? RATE_X16 : (baud == BAUD_X64) ? RATE_X64 : RATE_X1;
  endfunction : usr_edges

endpackage : usr_pkg

// File: rtl/usr_tx.sv
// Transmit framer and shifter driven by falling transmit clock edges
`timescale 1ns/100ps
module usr_tx (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       srst_i,
  usr_edge_if.dst         tclk,
  input  wire logic [7:0] mode_i,
  input  wire logic       go_i,
  input  wire logic [7:0] data_i,
  input  wire logic       brk_i,
  output logic            txd_o,
  output logic            busy_o
);
  import usr_pkg::*;

  logic [11:0] frame;
  logic [11:0] sh;
  logic [3:0]  nbits;
  logic [3:0]  nlen;
  logic [3:0]  left;
  logic [6:0]  cnt;
  logic [6:0]  edges;
  logic        async;
  logic        half_stop;
  logic [1:0]  stop;

  assign edges     = usr_edges(mode_i[MD_BAUD_LSB +: 2]);
  assign async     = mode_i[MD_BAUD_LSB +: 2] != BAUD_SYNC;
  assign stop      = mode_i[MD_STOP_LSB +: 2];
  assign half_stop = async && stop == STOP_15 && edges != RATE_X1;

  always_comb begin
    nlen  = CHAR_MIN + {2'h0, mode_i[MD_LEN_LSB +: 2]};
    frame = '1;
    nbits = 4'h0;
    if (async) begin
      frame[0] = 1'b0;
      nbits    = 4'h1;
    end
    for (int i = 0; i < 8; i++) begin
      if (i < int'(nlen)) begin
        frame[nbits + 4'(i)] = data_i[i];
      end
    end
    nbits = nbits + nlen;
    if (mode_i[MD_PEN]) begin
      frame[nbits] = ^(data_i & (8'hff >> (CHAR_MAX - nlen))) ^ ~mode_i[MD_PEVEN];
      nbits        = nbits + 4'h1;
    end
    if (async) begin
      nbits = nbits + ((stop == STOP_TWO || (stop == STOP_15 && !half_stop)) ? 4'h2 : 4'h1);
    end
  end

  // Stop bits stay high because the frame is preset to ones
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sh     <= '1;
      left   <= '0;
      cnt    <= '0;
      busy_o <= 1'b0;
    end else if (srst_i) begin
      sh     <= '1;
      left   <= '0;
      cnt    <= '0;
      busy_o <= 1'b0;
    end else if (go_i && !busy_o) begin
      sh     <= frame;
      left   <= nbits;
      cnt    <= '0;
      busy_o <= 1'b1;
    end else if (busy_o && tclk.fall) begin
      if (cnt != '0) begin
        cnt <= cnt - 7'h1;
      end else if (left == '0) begin
        busy_o <= 1'b0;
      end else begin
        sh   <= {1'b1, sh[11:1]};
        left <= left - 4'h1;
        cnt  <= (left == 4'h1 && half_stop) ? edges + (edges >> 1) - 7'h1 : edges - 7'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      txd_o <= 1'b1;
    end else if (brk_i) begin
      txd_o <= 1'b0;
    end else if (busy_o && tclk.fall && cnt == '0 && left != '0) begin
      txd_o <= sh[0];
    end else if (!busy_o) begin
      txd_o <= 1'b1;
    end
  end
endmodule : usr_tx

// File: tb/tb_usart_rx_control_async_core.sv
// Self-checking bench of the serial receiver core
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; $display("BAD %0t mismatch %h vs %h", $time, a, b); end end
module tb_usart_rx_control_async_core;
  logic       clk_i = 1'b0;
  logic       nrst_i = 1'b0;
  logic       cs_n_i = 1'b1;
  logic       rd_n_i = 1'b1;
  logic       wr_n_i = 1'b1;
  logic       cd_i = 1'b0;
  logic       cts_n_i = 1'b0;
  logic [7:0] data_i = 8'h00;
  logic [7:0] data_o, g, e, d;
  logic       data_oe_o, oe_q, rxd, rbc, txd_o, rdy, free, brk, soe;
  logic       syn = 1'b0;
  logic [10:0] tcap;
  int         nrise = 0;
  logic [7:0] exp_q[$], msk_q[$];
  logic [7:0] ini[6] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h7e, 8'h15};
  int         failures = 0;
  int         checks_done = 0;

  always #20 clk_i = ~clk_i;

  usr_line_model LM (.clk_i, .rxd_o(rxd), .rbc_o(rbc));
  // One far-end clock feeds both bit clocks, so the transmitter runs only inside frames
  usr_core DUT (
    .clk_i, .nrst_i, .cs_n_i, .rd_n_i, .wr_n_i, .cd_i, .data_i, .data_o, .data_oe_o,
    .receive_bit_clock_i(rbc), .rxd_i(rxd), .transmit_bit_clock_i(rbc), .cts_n_i, .txd_o,
    .receive_char_available_o(rdy), .transmit_holding_free_o(free), .tx_empty_o(),
    .sync_found_or_line_break_i(syn), .sync_found_or_line_break_o(brk), .sync_found_or_line_break_oe_o(soe)
  );

  task automatic summarize;
    if (failures == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // cw is {control, write}; a read notes its expected value and mask
  task automatic acc(input logic [1:0] cw, input logic [7:0] v, x, m);
    cd_i = cw[1];
    data_i = v;
    cs_n_i = 1'b0;
    if (cw[0]) wr_n_i = 1'b0;
    else begin
      rd_n_i = 1'b0;
      exp_q.push_back(x);
      msk_q.push_back(m);
    end
    repeat (2) @(posedge clk_i);
    #1 {cs_n_i, rd_n_i, wr_n_i} = 3'h7;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : acc

  task automatic rx(input logic [7:0] v, input int len, input logic bad);
    logic [11:0] fr;
    fr = 12'hffe;
    for (int i = 0; i < len; i++) fr[i+1] = v[i];
    fr[len+1] = ^(v & 8'((1 << len) - 1)) ^ bad;
    LM.send(fr, len + 3, 16);
    repeat (4) @(posedge clk_i);
    #1 `CHK(rdy, 1'b1)
  endtask : rx

  always @(posedge clk_i) begin
    oe_q <= data_oe_o;
    if (data_oe_o === 1'b1 && oe_q !== 1'b1 && exp_q.size() > 0) begin
      g = data_o & msk_q.pop_front();
      e = exp_q.pop_front();
      `CHK(g, e)
    end
  end

  // The one transmitted frame rides the first received frame's clock; take each bit mid-bit
  always @(posedge rbc) begin
    if (nrise % 16 == 8 && nrise < 176) tcap[nrise/16] = txd_o;
    nrise++;
  end

  initial begin
    #(40 * 40000);
    failures++;
    summarize();
  end

  initial begin
    void'($urandom(32'h5b4a));
    repeat (20) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    `CHK(txd_o, 1'b1)
    foreach (ini[i]) acc(2'h3, ini[i], 8'h00, 8'h00);
    `CHK(free, 1'b1)
    cts_n_i = 1'b1;
    @(posedge clk_i);
    #1 `CHK(free, 1'b0)
    cts_n_i = 1'b0;
    acc(2'h1, 8'h5a, 8'h00, 8'h00);
    acc(2'h0, 8'h00, 8'h00, 8'h00);
    for (int k = 0; k < 3; k++) begin
      d = 8'($urandom);
      rx(d, 8, 1'b0);
      if (k == 0) `CHK(tcap, {1'b1, ^8'h5a, 8'h5a, 1'b0})
      acc(2'h0, 8'h00, d, 8'hff);
      `CHK(rdy, 1'b0)
    end
    // Second frame arrives unread and with bad parity; it must still be kept
    rx(d ^ 8'h3c, 8, 1'b0);
    rx(d, 8, 1'b1);
    acc(2'h2, 8'h00, 8'h1a, 8'h1a);
    acc(2'h0, 8'h00, d, 8'hff);
    acc(2'h3, 8'h15, 8'h00, 8'h00);
    acc(2'h2, 8'h00, 8'h00, 8'h38);
    LM.send(12'h000, 12, 16);
    repeat (4) @(posedge clk_i);
    #1 `CHK(brk, 1'b1)
    acc(2'h2, 8'h00, 8'h60, 8'h62);
    LM.send(12'hfff, 1, 16);
    #1 `CHK(brk, 1'b0)
    acc(2'h3, 8'h40, 8'h00, 8'h00);
    acc(2'h3, 8'h72, 8'h00, 8'h00);
    acc(2'h3, 8'h15, 8'h00, 8'h00);
    d = 8'($urandom);
    rx(d, 5, 1'b0);
    acc(2'h0, 8'h00, d & 8'h1f, 8'hff);
    acc(2'h3, 8'h1d, 8'h00, 8'h00);
    `CHK(txd_o, 1'b0)
    acc(2'h3, 8'h40, 8'h00, 8'h00);
    `CHK(txd_o, 1'b1)
    // Internal single sync hunt at 1x; the pattern only lines up on the last bit
    acc(2'h3, 8'h8c, 8'h00, 8'h00);
    acc(2'h3, 8'h16, 8'h00, 8'h00);
    acc(2'h3, 8'h84, 8'h00, 8'h00);
    LM.send(12'h16f, 12, 1);
    #1 `CHK(brk, 1'b1)
    acc(2'h2, 8'h00, 8'h40, 8'h40);
    `CHK(brk, 1'b0)
    // External sync: the first clock fall after the pin rises starts assembly
    acc(2'h3, 8'h40, 8'h00, 8'h00);
    acc(2'h3, 8'hcc, 8'h00, 8'h00);
    acc(2'h3, 8'h16, 8'h00, 8'h00);
    acc(2'h3, 8'h04, 8'h00, 8'h00);
    `CHK(soe, 1'b0)
    d = 8'($urandom);
    syn = 1'b1;
    LM.send({3'h7, d, 1'b1}, 9, 1);
    #1 syn = 1'b0;
    repeat (4) @(posedge clk_i);
    #1 `CHK(rdy, 1'b1)
    acc(2'h0, 8'h00, d, 8'hff);
    summarize();
  end
endmodule : tb_usart_rx_control_async_core

bind usr_core usr_core_asserts u_chk (.clk_i, .nrst_i, .cs_n_i, .rd_n_i, .wr_n_i, .cd_i, .cts_n_i, .data_o,
  .data_oe_o, .txd_o, .receive_char_available_o, .transmit_holding_free_o);

// File: tb/usr_core_asserts.sv
// Port assertions of the serial receiver core
`timescale 1ns/100ps
module usr_core_asserts (
  input wire logic       clk_i,
  input wire logic       nrst_i,
  input wire logic       cs_n_i,
  input wire logic       rd_n_i,
  input wire logic       wr_n_i,
  input wire logic       cd_i,
  input wire logic       cts_n_i,
  input wire logic [7:0] data_o,
  input wire logic       data_oe_o,
  input wire logic       txd_o,
  input wire logic       receive_char_available_o,
  input wire logic       transmit_holding_free_o
);
  wire rca  = receive_char_available_o;
  wire free = transmit_holding_free_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Strobes held low act once, so only the leading cycle counts
  sequence s_rd;
    !cs_n_i && !rd_n_i && $past(cs_n_i || rd_n_i);
  endsequence
  sequence s_wr;
    !cs_n_i && !wr_n_i && !cd_i && $past(cs_n_i || wr_n_i);
  endsequence
  a_read_drives: assert property (s_rd |-> ##[1:2] data_oe_o) else $error("no drive");
  a_drive_ends: assert property ($fell(data_oe_o) |-> $past(cs_n_i || rd_n_i)) else $error("late");
  a_data_holds: assert property (!$stable(data_o) |-> $past(!cs_n_i && !rd_n_i)) else $error("moved");
  a_ready_clears: assert property (s_rd ##0 (!cd_i && rca) |-> ##[1:2] !rca)
    else $error("ready stuck");
  a_ready_why: assert property ($fell(rca) |-> $past(!rd_n_i || !wr_n_i)) else $error("ready lost");
  a_mark_reset: assert property ($rose(nrst_i) |-> txd_o) else $error("no mark");
  a_cts_blocks: assert property (cts_n_i |-> !free) else $error("free without cts");
  a_write_takes: assert property (s_wr |-> ##[1:2] !free) else $error("free stuck");
endmodule : usr_core_asserts

// File: tb/usr_line_model.sv
// Far-end serial sender with a bit clock of selectable factor
`timescale 1ns/100ps
module usr_line_model (
  input  wire logic clk_i,
  output logic      rxd_o,
  output logic      rbc_o
);
  initial {rxd_o, rbc_o} = 2'h2;
  // Clock stands still between frames; data moves on its falling edge
  task automatic send(input logic [11:0] fr, input int n, input int f);
    for (int i = 0; i < f * n; i++) begin
      if (i % f == 0) rxd_o <= fr[i/f];
      repeat (2) @(posedge clk_i);
      rbc_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      rbc_o <= 1'b0;
    end
  endtask : send
endmodule : usr_line_model
